// [verilog/pic_ctrl.sv]
// Prioritised interrupt controller with pending latches and enable register
//
// What this block does
// - Eleven sources besides reset; software, bad opcode, trap, watchdog unmaskable.
// - Each latched source has a pending latch raising a request when enabled; trap and watchdog latches need no enable.
// - Simultaneous requests taken in fixed order; unmaskable ones rank first.
// - Vectors step down by two from the top; two direct sources share one.
// - Maskable needs master and own enable; first external also input enable.
// - Software and bad opcode sources have no latch, raised by execution.
// - The accepted source's latch clears at acceptance.
// - Reset clears every pending latch.
// - Latches sit in two bytes; writing zero clears a single bit.
// - Writing one never sets a latch; only hardware sets it.
// - Pending latches are readable for polling.
// - Unmaskable sources are taken regardless of any enable flag.
// - Enable register is two readable and writable bytes.
// - With master flag low, no maskable request is taken.
// - Acceptance stacks the master flag, then clears it.
// - Return instructions reload master flag from the stacked value.
// - Master flag is bit zero of low enable byte, set or cleared by ops.
// - Reset clears all source enable flags; one enables, zero disables.
// - Trap and watchdog events reset the chip until their mode bits clear.
// - Requests sampled in final instruction cycle; return may be followed.
`timescale 1ns/1ps
`include "pic_cfg.svh"

module pic_ctrl (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Special function byte access
    input  wire pic_pkg::pic_sfr_s sfr,
    output logic [7:0]             sfr_rdata,
    // Core sequencer
    input  wire pic_pkg::pic_cpu_s cpu,
    output logic                   irq_req,
    output pic_pkg::pic_src_t      irq_source,
    output pic_pkg::pic_word_t     irq_vector,
    output logic                   stack_master,
    output logic                   master_enable_flag,
    // Peripheral events and watchdog control mode bits
    input  wire pic_pkg::pic_evt_s evt,
    input  wire logic              trap_mode_select,
    input  wire logic              watchdog_mode_select,
    output logic                   malfunction_reset,
    // External request pins
    input  wire logic              ext_irq_a,
    input  wire logic              ext_irq_b,
    input  wire logic              ext_irq_c,
    input  wire logic              ext_a_input_enable
);

    // Lowest set bit above zero wins; bit 1 is the shared direct slot
    function automatic pic_pkg::pic_src_t pic_pick(
        input pic_pkg::pic_word_t cand
    );
        pic_pkg::pic_src_t sel;
        sel = `PIC_SRC_NONE;
        for (int i = 15; i >= 1; i--) begin
            if (cand[i]) begin
                sel = 4'(i);
            end
        end
        return sel;
    endfunction

    // Slot vector, two bytes per rank below the top
    function automatic pic_pkg::pic_word_t pic_vec(
        input pic_pkg::pic_src_t src
    );
        return `PIC_VEC_TOP - {11'h000, src, 1'b0};
    endfunction

    // One-hot of a source code
    function automatic pic_pkg::pic_word_t pic_bit(
        input pic_pkg::pic_src_t src
    );
        return 16'h0001 << src;
    endfunction

    // State
    pic_pkg::pic_word_t latch_q;
    pic_pkg::pic_word_t latch_d;
    pic_pkg::pic_word_t en_q;
    pic_pkg::pic_word_t en_d;
    logic               master_q;
    logic               master_d;
    logic               direct_q;
    logic               direct_d;
    logic               req_q;
    pic_pkg::pic_src_t  src_q;
    pic_pkg::pic_src_t  src_d;
    pic_pkg::pic_word_t vec_q;
    logic               stack_q;
    logic               mreset_q;
    logic [7:0]         rdata_q;

    // Pin synchronisers and edge history
    logic [2:0]         pin_s1_q;
    logic [2:0]         pin_s2_q;
    logic [2:0]         pin_s3_q;

    // Decoded strobes
    logic               take;
    logic               wr_en_lo;
    logic               wr_en_hi;
    logic               wr_il_lo;
    logic               wr_il_hi;
    pic_pkg::pic_word_t hw_set;
    pic_pkg::pic_word_t sw_clr;
    pic_pkg::pic_word_t acc_clr;
    pic_pkg::pic_word_t cand;
    pic_pkg::pic_word_t maskable;
    logic [2:0]         pin_rise;

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_s3_q <= 3'h0;
        end else begin
            pin_s1_q <= {ext_irq_c, ext_irq_b, ext_irq_a};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Rising edge on a synchronised pin is a request
    // History resets low like the idle pins, so reset gives no edge
    assign pin_rise = pin_s2_q & ~pin_s3_q;

    // Byte write strobes
    assign wr_en_lo = sfr.wr && (sfr.addr == `PIC_ADDR_EN_LO);
    assign wr_en_hi = sfr.wr && (sfr.addr == `PIC_ADDR_EN_HI);
    assign wr_il_lo = sfr.wr && (sfr.addr == `PIC_ADDR_IL_LO);
    assign wr_il_hi = sfr.wr && (sfr.addr == `PIC_ADDR_IL_HI);

    // An accept with no presented request is simply ignored
    // accepted only at the final cycle of an instruction
    assign take = cpu.accept && cpu.instr_last && req_q;

    // Hardware request pulses into the latches
    always_comb begin
        hw_set = 16'h0000;
        // trap and watchdog become latches only in interrupt mode
        hw_set[`PIC_SRC_TRAP]  = evt.addr_trap_irq && !trap_mode_select;
        hw_set[`PIC_SRC_WDOG]  = evt.watchdog_irq && !watchdog_mode_select;
        hw_set[`PIC_SRC_EXT_A] = pin_rise[0];
        hw_set[`PIC_SRC_EXT_B] = pin_rise[1];
        hw_set[`PIC_SRC_TBASE] = evt.time_base_irq;
        hw_set[`PIC_SRC_TMR3]  = evt.timer_three_irq;
        hw_set[`PIC_SRC_TMR4]  = evt.timer_four_irq;
        hw_set[`PIC_SRC_ADC]   = evt.converter_done_irq;
        hw_set[`PIC_SRC_EXT_C] = pin_rise[2];
    end

    // a zero written to a latch bit clears that bit alone
    always_comb begin
        sw_clr = 16'h0000;
        if (wr_il_lo) begin
            sw_clr[7:0] = ~sfr.wdata;
        end
        if (wr_il_hi) begin
            sw_clr[15:8] = ~sfr.wdata;
        end
    end

    // The presented code is the one the core saw, not the next choice
    // acceptance clears the presented source's latch
    assign acc_clr = take ? pic_bit(src_q) : 16'h0000;

    // latch next state; set wins over any clear in the same cycle
    // a written one only leaves the latch as it was
    always_comb begin
        latch_d = ((latch_q & ~sw_clr & ~acc_clr) | hw_set) & `PIC_IL_MASK;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            latch_q <= `PIC_RST_VAL;
        end else begin
            latch_q <= latch_d;
        end
    end

    // execution-raised request held, unseen by software, until taken
    always_comb begin
        direct_d = direct_q;
        if (take && (src_q == `PIC_SRC_DIRECT)) begin
            direct_d = 1'b0;
        end
        if (cpu.software_trap_irq || cpu.bad_opcode_irq) begin
            direct_d = 1'b1;
        end
    end

    // Held direct request drops at reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            direct_q <= 1'b0;
        end else begin
            direct_q <= direct_d;
        end
    end

    // high enable byte written whole, low byte only bits 7:4 and master, so read-modify-write works
    always_comb begin
        en_d = en_q;
        if (wr_en_lo) begin
            en_d[7:4] = sfr.wdata[7:4];
        end
        if (wr_en_hi) begin
            en_d[15:8] = sfr.wdata;
        end
        en_d = en_d & `PIC_EN_MASK;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_q <= `PIC_RST_VAL;
        end else begin
            en_q <= en_d;
        end
    end

    // Master flag: acceptance beats return, return beats ops and writes
    always_comb begin
        master_d = master_q;
        // bit zero of the low enable byte, plus set and clear ops
        if (wr_en_lo) begin
            master_d = sfr.wdata[`PIC_MASTER_BIT];
        end
        if (cpu.set_master_op) begin
            master_d = 1'b1;
        end
        if (cpu.clear_master_op) begin
            master_d = 1'b0;
        end
        if (cpu.return_op) begin
            master_d = cpu.stacked_master;
        end
        // acceptance clears after the old value is stacked
        if (take) begin
            master_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            master_q <= 1'b0;
        end else begin
            master_q <= master_d;
        end
    end

    // value pushed with the status word at acceptance
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stack_q <= 1'b0;
        end else if (take) begin
            stack_q <= master_q;
        end
    end

    // maskable sources need master and own flag; first pin its gate
    // nothing maskable passes while master is low
    always_comb begin
        maskable = latch_d & en_d & {16{master_d}};
        maskable[`PIC_SRC_EXT_A] = maskable[`PIC_SRC_EXT_A]
                                   && ext_a_input_enable;
        maskable = maskable & `PIC_EN_MASK;
    end

    // direct slot plus trap and watchdog are the unmaskable set
    always_comb begin
        cand = maskable | (latch_d & `PIC_NMI_MASK);
        cand[`PIC_SRC_DIRECT] = direct_d;
    end

    assign src_d = pic_pick(cand);

    // chosen source and vector registered every cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            req_q <= 1'b0;
            src_q <= `PIC_SRC_NONE;
            vec_q <= `PIC_VEC_TOP;
        end else begin
            req_q <= (src_d != `PIC_SRC_NONE);
            src_q <= src_d;
            // two bytes per rank below the reset vector
            vec_q <= pic_vec(src_d);
        end
    end

    // events in reset mode ask for a malfunction reset instead
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mreset_q <= 1'b0;
        end else begin
            mreset_q <= (evt.addr_trap_irq && trap_mode_select)
                     || (evt.watchdog_irq && watchdog_mode_select);
        end
    end

    // latches and enables read back; latch bits 1:0, enable bits 3:1 and other addresses read zero
    // Read data then holds until the next read strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (sfr.rd) begin
            unique case (sfr.addr)
                `PIC_ADDR_EN_LO: rdata_q <= {en_q[7:1], master_q};
                `PIC_ADDR_EN_HI: rdata_q <= en_q[15:8];
                `PIC_ADDR_IL_LO: rdata_q <= latch_q[7:0];
                `PIC_ADDR_IL_HI: rdata_q <= latch_q[15:8];
                default:         rdata_q <= 8'h00;
            endcase
        end
    end

    // Outputs
    assign sfr_rdata          = rdata_q;
    assign irq_req            = req_q;
    assign irq_source         = src_q;
    assign irq_vector         = vec_q;
    assign stack_master       = stack_q;
    assign master_enable_flag = master_q;
    assign malfunction_reset  = mreset_q;

endmodule

// [verilog/pic_cfg.svh]
// Offsets, field positions, reset values and source codes of the controller
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// Special function byte addresses
`define PIC_ADDR_EN_LO  8'h3a
`define PIC_ADDR_EN_HI  8'h3b
`define PIC_ADDR_IL_LO  8'h3c
`define PIC_ADDR_IL_HI  8'h3d

// Field positions and masks
`define PIC_MASTER_BIT  0
`define PIC_EN_MASK     16'hfff0
`define PIC_IL_MASK     16'hfffc
`define PIC_NMI_MASK    16'h000c
`define PIC_RST_VAL     16'h0000

// Source codes, which are also priority ranks and vector slots
`define PIC_SRC_NONE    4'h0
`define PIC_SRC_DIRECT  4'h1
`define PIC_SRC_TRAP    4'h2
`define PIC_SRC_WDOG    4'h3
`define PIC_SRC_EXT_A   4'h4
`define PIC_SRC_EXT_B   4'h5
`define PIC_SRC_TBASE   4'h6
`define PIC_SRC_TMR3    4'ha
`define PIC_SRC_TMR4    4'hb
`define PIC_SRC_ADC     4'hc
`define PIC_SRC_EXT_C   4'hf

// Vector of the reset slot; each lower rank sits two bytes below
`define PIC_VEC_TOP     16'hfffe

`endif

// [verilog/pic_pkg.sv]
// Types shared by the interrupt controller and its neighbours
package pic_pkg;

    typedef logic [3:0]  pic_src_t;
    typedef logic [15:0] pic_word_t;

    // Special function byte access from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pic_sfr_s;

    // Core sequencer strobes
    typedef struct packed {
        logic instr_last;
        logic accept;
        logic software_trap_irq;
        logic bad_opcode_irq;
        logic set_master_op;
        logic clear_master_op;
        logic return_op;
        logic stacked_master;
    } pic_cpu_s;

    // Peripheral events, one-cycle pulses on the core clock
    typedef struct packed {
        logic addr_trap_irq;
        logic watchdog_irq;
        logic time_base_irq;
        logic timer_three_irq;
        logic timer_four_irq;
        logic converter_done_irq;
    } pic_evt_s;

endpackage

// [dv/pic_ctrl_chk.sv]
// Port assertions for the interrupt controller
`timescale 1ns/1ps
module pic_ctrl_chk (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               rst_n,
    // Core side
    input wire pic_pkg::pic_cpu_s  cpu,
    input wire logic               irq_req,
    input wire pic_pkg::pic_src_t  irq_source,
    input wire pic_pkg::pic_word_t irq_vector,
    input wire logic               stack_master,
    input wire logic               master_enable_flag,
    // Peripheral side
    input wire pic_pkg::pic_evt_s  evt,
    input wire logic               watchdog_mode_select,
    input wire logic               malfunction_reset
);
    logic take;

    // Core takes the presented request at this edge
    assign take = cpu.accept && cpu.instr_last && irq_req;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    vec_map_a: assert property (
        irq_vector == 16'hfffe - {11'h0, irq_source, 1'h0})
        else $error("vector does not follow source");
    idle_code_a: assert property (!irq_req |-> irq_source == 4'h0)
        else $error("source code shown without request");
    mask_gate_a: assert property (
        irq_req && irq_source > 4'h3 |-> master_enable_flag)
        else $error("maskable request with master off");
    take_clear_a: assert property (take |=> !master_enable_flag)
        else $error("master not cleared on take");
    take_stack_a: assert property (
        take |=> stack_master == $past(master_enable_flag))
        else $error("stacked master wrong");
    ret_load_a: assert property (
        cpu.return_op && !take
        |=> master_enable_flag == $past(cpu.stacked_master))
        else $error("return did not reload master");
    clear_op_a: assert property (
        cpu.clear_master_op && !cpu.return_op |=> !master_enable_flag)
        else $error("clear op ignored");
    set_op_a: assert property (
        cpu.set_master_op && !cpu.clear_master_op && !cpu.return_op
        && !take |=> master_enable_flag)
        else $error("set op ignored");
    wdog_reset_a: assert property (
        evt.watchdog_irq && watchdog_mode_select |=> malfunction_reset)
        else $error("no malfunction reset");
    wdog_nmi_a: assert property (
        evt.watchdog_irq && !watchdog_mode_select |=> irq_req)
        else $error("watchdog request not raised");
endmodule

bind pic_ctrl pic_ctrl_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .cpu(cpu), .irq_req(irq_req), .irq_source(irq_source),
    .irq_vector(irq_vector), .stack_master(stack_master),
    .master_enable_flag(master_enable_flag), .evt(evt),
    .watchdog_mode_select(watchdog_mode_select),
    .malfunction_reset(malfunction_reset));

// [dv/pic_core_mdl.sv]
// Behavioural core: final-cycle strobe, request taking, master flag stack
`timescale 1ns/1ps
module pic_core_mdl (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Bench controls
    input  wire logic take_en,
    input  wire logic slow,
    input  wire logic ret_req,
    output logic      took,
    // Controller side
    input  wire logic irq_req,
    input  wire logic stack_master,
    output logic      instr_last,
    output logic      accept,
    output logic      return_op,
    output logic      stacked_master
);
    logic stk [$];
    logic want;
    logic take_now;

    // Controller sees the take at this edge
    assign take_now = accept && instr_last && irq_req;

    // take in final cycle, push on take, pop on return
    always @(posedge sys_clk) begin
        want <= (want || take_en) && !take_now;
        accept <= (want || take_en) && !take_now;
        took <= take_now;
        instr_last <= slow ? !instr_last : 1'h1;
        return_op <= ret_req;
        stacked_master <= ~stacked_master; // Not valid outside returns
        if (took)
            stk.push_back(stack_master);
        if (ret_req)
            stacked_master <= stk.pop_back();
        if (!rst_n) begin
            {want, accept, took, instr_last} <= 4'h0;
            {return_op, stacked_master} <= 2'h0;
            stk.delete();
        end
    end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module testbench;
    logic               clk, rst_n, il, acc, sw, bad, set_op, clr_op;
    logic               ret_op, stk, irq_req, smast, mflag, tmode, wmode;
    logic               mrst, ext_a, ext_b, ext_c, a_en;
    logic               take_en, slow, ret_req, took;
    logic [7:0]         rdata, r;
    pic_pkg::pic_sfr_s  sfr;
    pic_pkg::pic_cpu_s  cpu;
    pic_pkg::pic_evt_s  evt;
    pic_pkg::pic_src_t  src;
    pic_pkg::pic_word_t vecw;
    int                 n_errors, samples_checked, i;
    logic [3:0]         nmi [4] = '{4'h1, 4'h1, 4'h2, 4'h3};
    logic [3:0]         pri [3] = '{4'h6, 4'hb, 4'hc};
    // Strobe masks over {sw, bad, set_op, clr_op, take_en, ret_req}
    localparam logic [5:0] st_sw   = 6'h20;
    localparam logic [5:0] st_bad  = 6'h10;
    localparam logic [5:0] st_set  = 6'h08;
    localparam logic [5:0] st_clr  = 6'h04;
    localparam logic [5:0] st_take = 6'h02;
    localparam logic [5:0] st_ret  = 6'h01;

    assign cpu = {il, acc, sw, bad, set_op, clr_op, ret_op, stk};
    always #2 clk = ~clk;

    pic_ctrl i_dut (.sys_clk(clk), .rst_n(rst_n), .sfr(sfr),
        .sfr_rdata(rdata), .cpu(cpu), .irq_req(irq_req),
        .irq_source(src), .irq_vector(vecw), .stack_master(smast),
        .master_enable_flag(mflag), .evt(evt), .trap_mode_select(tmode),
        .watchdog_mode_select(wmode), .malfunction_reset(mrst),
        .ext_irq_a(ext_a), .ext_irq_b(ext_b), .ext_irq_c(ext_c),
        .ext_a_input_enable(a_en));
    pic_core_mdl i_core (.sys_clk(clk), .rst_n(rst_n), .take_en(take_en),
        .slow(slow), .ret_req(ret_req), .took(took), .irq_req(irq_req),
        .stack_master(smast), .instr_last(il), .accept(acc),
        .return_op(ret_op), .stacked_master(stk));

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // Vector expected for a source code
    function automatic logic [15:0] vec(input logic [3:0] s);
        return 16'hfffe - {11'h0, s, 1'h0};
    endfunction
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Wait for irq_req, or for the core's took pulse when on_took is set
    task automatic wait_hi(input logic on_took);
        for (int k = 0; k < 40 && (on_took ? took : irq_req) !== 1'h1; k++)
            @(posedge clk);
        if ((on_took ? took : irq_req) !== 1'h1) begin
            n_errors++;
            $display("wrong value at %0t: wait ran out", $time);
            conclude();
        end
    endtask
    // One-cycle pulse on the strobes selected by m
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        {sw, bad, set_op, clr_op, take_en, ret_req} <= m;
        @(posedge clk);
        {sw, bad, set_op, clr_op, take_en, ret_req} <= 6'h00;
    endtask
    task automatic evp(input pic_pkg::pic_evt_s e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge clk);
        sfr <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(posedge clk);
        sfr <= '0;
        @(posedge clk);
        check({8'h0, rdata}, {8'h0, e});
    endtask
    // Wait for a request, check it, let the core take it
    task automatic take(input logic [3:0] s);
        wait_hi(1'h0);
        check({12'h0, src}, {12'h0, s});
        check(vecw, vec(s));
        r = lfsr(r);
        slow <= r[0];
        pulse(st_take);
        wait_hi(1'h1);
        check({15'h0, mflag}, 16'h0);
    endtask
    task automatic ret(input logic m);
        pulse(st_ret);
        repeat (2) @(posedge clk);
        check({15'h0, mflag}, {15'h0, m});
    endtask

    initial begin
        clk = 1'h0;
        r = 8'h06;
        sfr = '0;
        evt = '0;
        {rst_n, sw, bad, set_op, clr_op, take_en, slow, ret_req} = 8'h0;
        {ext_a, ext_b, ext_c, a_en, tmode, wmode} = 6'h03;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        for (i = 8'h3a; i < 8'h3f; i++) rd(i[7:0], 8'h00);
        wr(8'h3a, 8'hff);
        rd(8'h3a, 8'hf1);
        for (i = 0; i < 4; i++) begin
            r = lfsr(r);
            wr(8'h3b, r);
            rd(8'h3b, r);
        end
        wr(8'h3a, 8'h00);
        wr(8'h3b, 8'h04);
        evp(6'h04);
        rd(8'h3d, 8'h04);
        check({15'h0, irq_req}, 16'h0);
        wr(8'h3d, 8'hff);
        rd(8'h3d, 8'h04);
        wr(8'h3c, 8'h0c);
        wr(8'h3d, 8'h00);
        rd(8'h3d, 8'h00);
        evp(6'h04);
        pulse(st_set);
        take(4'ha);
        rd(8'h3d, 8'h00);
        ret(1'h1);
        wr(8'h3a, 8'h41);
        wr(8'h3b, 8'h18);
        evp(6'h0b);
        for (i = 0; i < 3; i++) begin
            take(pri[i]);
            ret(1'h1);
        end
        pulse(st_clr);
        {tmode, wmode} <= 2'h0;
        for (i = 0; i < 4; i++) begin
            case (i)
                0: pulse(st_sw);
                1: pulse(st_bad);
                2: evp(6'h20);
                default: evp(6'h10);
            endcase
            take(nmi[i]);
            ret(1'h0);
        end
        {tmode, wmode} <= 2'h3;
        evp(6'h30);
        @(posedge clk);
        check({15'h0, mrst}, 16'h1);
        check({15'h0, irq_req}, 16'h0);
        wr(8'h3a, 8'h31);
        wr(8'h3b, 8'h80);
        {ext_a, ext_b, ext_c} <= 3'h7;
        take(4'h5);
        ret(1'h1);
        take(4'hf);
        ret(1'h1);
        a_en <= 1'h1;
        take(4'h4);
        conclude();
    end
endmodule
